// ---- wdt_pkg.sv ----
package wdt_pkg;

	// Register addresses on the plain register port.
	localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_CLOCK_CONTROL    = 8'h01;
	localparam logic [7:0] ADDR_EXT_IRQ_ENABLE   = 8'h02;
	localparam logic [7:0] ADDR_POWER_MGMT       = 8'h03;
	localparam logic [7:0] ADDR_EXT_IRQ_FLAG     = 8'h04;
	localparam logic [7:0] ADDR_TIMED_ACCESS     = 8'h05;

	// Bit positions in the watchdog control register.
	localparam int BIT_RESTART     = 0;
	localparam int BIT_RESET_EN    = 1;
	localparam int BIT_RESET_FLAG  = 2;
	localparam int BIT_IRQ_FLAG    = 3;
	localparam int BIT_POR_FLAG    = 6;
	// Other bit positions.
	localparam int BIT_TIMEOUT_LO  = 6;
	localparam int BIT_IRQ_ENABLE  = 4;
	// The ratio bit sits apart from the divide field so that reads show both intact.
	localparam int BIT_RATIO       = 3;
	localparam int BIT_MULT_EN     = 4;
	localparam int BIT_DIV_LO      = 6;
	localparam int BIT_RING_SEL    = 1;
	localparam int BIT_RING_ACTIVE = 3;

	// Reset values.
	localparam logic [1:0] DIVIDE_RESET  = 2'h2;
	localparam logic [1:0] TIMEOUT_RESET = 2'h0;

	// Timed-access unlock pair and its window in clocks.
	localparam logic [7:0] TA_KEY1   = 8'haa;
	localparam logic [7:0] TA_KEY2   = 8'h55;
	localparam logic [1:0] TA_WINDOW = 2'h3;

	// Timing counts.
	localparam logic [9:0]  RESET_DELAY_CLKS = 10'h200;
	localparam logic [16:0] STARTUP_CLKS     = 17'h10000;
	localparam logic [2:0]  EXIT_RESET_CLKS  = 3'h3;

	// Register port request.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} wdt_bus_req_t;

	typedef enum logic [2:0] {
		ST_RUN     = 3'b001,
		ST_GRACE   = 3'b010,
		ST_RESET   = 3'b100
	} wdt_state_t;

endpackage : wdt_pkg

// ---- wdt_core.sv ----
// Notes on behaviour
// - Any reset returns divide field to 10b and timeout select to shortest.
// - Reset timeout fires exactly 512 clocks after interrupt timeout.
// - Timeout select multiplies base count by 1, 8, 64 or 512.
// - Watchdog reset occurs only while reset-enable bit is set.
// - Writing one to restart bit clears the count for a full interval.
// - Without resets or restarts, interrupt timeouts repeat periodically.
// - Interrupt flag sets whenever interrupt timeout expires.
// - Reset flag sets after a watchdog reset has happened.
// - Interrupt request is forwarded only when irq enable bit is one.
// - Watchdog counts crystal clocks always, never the ring oscillator.
// - Startup counter counts 65,536 crystal clocks after power-up or stop exit.
// - Enabling the multiplier imposes a watchdog-timed startup delay; here the crystal startup counter times it.
// - Restart, reset-enable, irq flag and power-on flag need timed access.
// - Reset pin is driven high while any internal reset is asserted.
// - Pin high holds reset; exit within 4 clocks of release; start at 0000h.
// - Reset in stop mode restarts oscillator with 65,536 clock delay.
// - Ring select runs system from ring during warm-up after stop exit, else execution waits.
// - Status shows ring or crystal; divide field locked at 10b on ring.
// - Watchdog runs in idle; enabled watchdog interrupt wakes from idle.
`timescale 1ns/1ps
module wdt_core
	import wdt_pkg::*;
#(
	parameter int unsigned CNT_W = 37
) (
	// Clock and asynchronous reset.
	input  wire logic        clock,
	input  wire logic        nrst,
	// Register port.
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Reset pin, split into its three signals.
	input  wire logic        rst_pin_in,
	output logic             rst_pin_out,
	output logic             rst_pin_oe,
	// Other internal reset sources and power state.
	input  wire logic        power_fail,
	input  wire logic        internal_reset,
	input  wire logic        stop_mode,
	input  wire logic        idle_mode,
	input  wire logic        crystal_enable_tick,
	// Outputs to the core.
	output logic             system_reset,
	output logic             watchdog_irq,
	output logic             idle_wake,
	output logic             ring_clock_select,
	output logic             execution_hold,
	output logic [15:0]      reset_vector
);

	// All state of the block.
	typedef struct packed {
		wdt_state_t  st;
		logic [CNT_W-1:0] cnt;
		logic [9:0]  grace;
		logic [16:0] startup;
		logic        warming;
		logic        ring_active;
		logic        ring_sel;
		logic        reset_en;
		logic        irq_flag;
		logic        reset_flag;
		logic        por_flag;
		logic        irq_enable;
		logic [1:0]  timeout_sel;
		logic [1:0]  divide;
		logic        ratio;
		logic        mult_en;
		logic [1:0]  ta_win;
		logic        ta_open;
		logic        ta_key1_seen;
		logic [2:0]  exit_cnt;
		logic        ext_hold;
		logic        was_stopped;
		logic [7:0]  rdata;
	} wdt_state_s_t;

	wdt_state_s_t cur;
	wdt_state_s_t next_s;

	logic [CNT_W-1:0] limit;
	logic             wd_reset_fire;
	logic             any_int_reset;
	logic             pin_reset;

	// The interrupt timeout limit comes from divide, ratio and select.
	always_comb begin
		unique case (cur.divide)
			2'h0:    limit = cur.ratio ? (CNT_W'(1) << 15) : (CNT_W'(1) << 16);
			2'h3:    limit = CNT_W'(1) << 27;
			default: limit = CNT_W'(1) << 17;
		endcase
		limit = limit << (3 * cur.timeout_sel);
	end

	// Reset requests from outside and from the watchdog.
	assign pin_reset     = rst_pin_in & ~rst_pin_oe;
	assign wd_reset_fire = (cur.st == ST_GRACE) && (cur.grace == RESET_DELAY_CLKS - 10'h1)
		&& cur.reset_en;
	assign any_int_reset = power_fail | internal_reset | (cur.st == ST_RESET);

	// Next-state logic for the whole block.
	always_comb begin
		logic prot_ok;
		logic wd_write;
		prot_ok  = 1'b0;
		wd_write = 1'b0;
		next_s   = cur;
		next_s.rdata = 8'h00;
		prot_ok  = cur.ta_open;
		wd_write = reg_wr && reg_addr == ADDR_WATCHDOG_CONTROL;

		// Timed access: two keys, then a short window for one protected write.
		if (cur.ta_win != 2'h0) begin
			next_s.ta_win = cur.ta_win - 2'h1;
		end else begin
			next_s.ta_open      = 1'b0;
			next_s.ta_key1_seen = 1'b0;
		end
		if (reg_wr && reg_addr == ADDR_TIMED_ACCESS) begin
			if (reg_wdata == TA_KEY1) begin
				next_s.ta_key1_seen = 1'b1;
				next_s.ta_open      = 1'b0;
				next_s.ta_win       = TA_WINDOW;
			end else if (reg_wdata == TA_KEY2 && cur.ta_key1_seen) begin
				next_s.ta_open = 1'b1;
				next_s.ta_win  = TA_WINDOW;
			end
		end

		// The counter always runs on the crystal-derived clock, idle included.
		next_s.cnt = cur.cnt + CNT_W'(1);
		unique case (cur.st)
			ST_RUN: begin
				if (cur.cnt >= limit - CNT_W'(1)) begin
					next_s.irq_flag = 1'b1;
					next_s.cnt      = '0;
					next_s.st       = ST_GRACE;
					next_s.grace    = '0;
				end
			end
			ST_GRACE: begin
				next_s.grace = cur.grace + 10'h1;
				if (wd_reset_fire) begin
					next_s.st = ST_RESET;
				end else if (cur.grace == RESET_DELAY_CLKS - 10'h1) begin
					next_s.st = ST_RUN;
				end
			end
			ST_RESET: begin
				next_s.st         = ST_RUN;
				next_s.reset_flag = 1'b1;
				next_s.cnt        = '0;
			end
			default: next_s.st = ST_RUN;
		endcase

		// Watchdog control writes; protected bits need the unlock.
		if (wd_write) begin
			if (prot_ok) begin
				next_s.reset_en = reg_wdata[BIT_RESET_EN];
				next_s.irq_flag = reg_wdata[BIT_IRQ_FLAG] | next_s.irq_flag & ~cur.irq_flag;
				next_s.por_flag = reg_wdata[BIT_POR_FLAG];
				if (reg_wdata[BIT_RESTART]) begin
					next_s.cnt   = '0;
					next_s.grace = '0;
					next_s.st    = ST_RUN;
				end
				next_s.ta_open = 1'b0;
			end
			// The reset flag is unprotected; a new watchdog reset wins over a clear.
			next_s.reset_flag = reg_wdata[BIT_RESET_FLAG] | (cur.st == ST_RESET);
		end

		// Plain registers.
		if (reg_wr && reg_addr == ADDR_CLOCK_CONTROL) begin
			next_s.timeout_sel = reg_wdata[BIT_TIMEOUT_LO +: 2];
		end
		if (reg_wr && reg_addr == ADDR_EXT_IRQ_ENABLE) begin
			next_s.irq_enable = reg_wdata[BIT_IRQ_ENABLE];
		end
		if (reg_wr && reg_addr == ADDR_POWER_MGMT) begin
			if (!cur.ring_active) begin
				next_s.divide = reg_wdata[BIT_DIV_LO +: 2];
			end
			next_s.ratio = reg_wdata[BIT_RATIO];
			if (reg_wdata[BIT_MULT_EN] && !cur.mult_en) begin
				next_s.warming = 1'b1;
				next_s.startup = '0;
			end
			next_s.mult_en = reg_wdata[BIT_MULT_EN];
		end
		if (reg_wr && reg_addr == ADDR_EXT_IRQ_FLAG) begin
			next_s.ring_sel = reg_wdata[BIT_RING_SEL];
		end

		// Crystal startup counter, restarted on each stop exit.
		next_s.was_stopped = stop_mode;
		if (cur.was_stopped && !stop_mode) begin
			next_s.warming     = 1'b1;
			next_s.startup     = '0;
			next_s.ring_active = cur.ring_sel;
		end else if (cur.warming && crystal_enable_tick) begin
			next_s.startup = cur.startup + 17'h1;
			if (cur.startup == STARTUP_CLKS - 17'h1) begin
				next_s.warming     = 1'b0;
				next_s.ring_active = 1'b0;
			end
		end
		if (cur.ring_active || next_s.ring_active) begin
			next_s.divide = DIVIDE_RESET;
		end

		// Exit from reset counts a few clocks after the pin drops.
		if (pin_reset || any_int_reset) begin
			next_s.exit_cnt = EXIT_RESET_CLKS;
			next_s.ext_hold = 1'b1;
		end else if (cur.exit_cnt != 3'h0) begin
			next_s.exit_cnt = cur.exit_cnt - 3'h1;
		end else begin
			next_s.ext_hold = 1'b0;
		end

		// Any reset returns the divide field and timeout select to their defaults.
		if (pin_reset || power_fail || internal_reset) begin
			next_s.timeout_sel = TIMEOUT_RESET;
			next_s.divide      = DIVIDE_RESET;
			next_s.cnt         = '0;
			next_s.st          = ST_RUN;
			next_s.reset_en    = 1'b0;
			next_s.irq_enable  = 1'b0;
		end else if (cur.st == ST_RESET) begin
			next_s.timeout_sel = TIMEOUT_RESET;
			next_s.divide      = DIVIDE_RESET;
			next_s.reset_en    = 1'b0;
			next_s.irq_enable  = 1'b0;
		end

		// Read data stands the cycle after the read strobe.
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_WATCHDOG_CONTROL: begin
					next_s.rdata[BIT_RESTART]    = 1'b0;
					next_s.rdata[BIT_RESET_EN]   = cur.reset_en;
					next_s.rdata[BIT_RESET_FLAG] = cur.reset_flag;
					next_s.rdata[BIT_IRQ_FLAG]   = cur.irq_flag;
					next_s.rdata[BIT_POR_FLAG]   = cur.por_flag;
				end
				ADDR_CLOCK_CONTROL:  next_s.rdata[BIT_TIMEOUT_LO +: 2] = cur.timeout_sel;
				ADDR_EXT_IRQ_ENABLE: next_s.rdata[BIT_IRQ_ENABLE] = cur.irq_enable;
				ADDR_POWER_MGMT: begin
					next_s.rdata[BIT_DIV_LO +: 2] = cur.divide;
					next_s.rdata[BIT_RATIO]       = cur.ratio;
					next_s.rdata[BIT_MULT_EN]     = cur.mult_en;
				end
				ADDR_EXT_IRQ_FLAG: begin
					next_s.rdata[BIT_RING_SEL]    = cur.ring_sel;
					next_s.rdata[BIT_RING_ACTIVE] = cur.ring_active;
				end
				default: next_s.rdata = 8'h00;
			endcase
		end
	end

	// Register the whole state; power-on marks the power-on flag and warm-up.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cur             <= '0;
			cur.st          <= ST_RUN;
			cur.divide      <= DIVIDE_RESET;
			cur.timeout_sel <= TIMEOUT_RESET;
			cur.por_flag    <= 1'b1;
			cur.warming     <= 1'b1;
			cur.ext_hold    <= 1'b1;
			cur.exit_cnt    <= EXIT_RESET_CLKS;
		end else begin
			cur <= next_s;
		end
	end

	// Outputs. Driving the pin can fail against an RC network; that is tolerated.
	assign rst_pin_out       = 1'b1;
	assign rst_pin_oe        = any_int_reset;
	assign system_reset      = cur.ext_hold;
	assign watchdog_irq      = cur.irq_flag & cur.irq_enable;
	assign idle_wake         = idle_mode & watchdog_irq;
	assign ring_clock_select = cur.ring_active;
	assign execution_hold    = cur.warming & ~cur.ring_active;
	assign reset_vector      = 16'h0000;
	assign reg_rdata         = cur.rdata;

endmodule : wdt_core

// ---- wdt_core_assertions.sv ----
`timescale 1ns/1ps
module wdt_core_assertions
	import wdt_pkg::*;
(
	// Clock and reset.
	input wire logic        clock,
	input wire logic        nrst,
	// Reset pin and reset sources.
	input wire logic        rst_pin_in,
	input wire logic        rst_pin_out,
	input wire logic        rst_pin_oe,
	input wire logic        power_fail,
	input wire logic        internal_reset,
	// Core side.
	input wire logic        idle_mode,
	input wire logic        watchdog_irq,
	input wire logic        idle_wake,
	input wire logic        system_reset,
	input wire logic [15:0] reset_vector
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	// A released pin with no other source pending must let the core go.
	sequence s_pin_release;
		$fell(rst_pin_in) ##0 (!power_fail && !internal_reset && !rst_pin_oe);
	endsequence
	sequence s_reset_gone;
		##[0:4] !system_reset;
	endsequence

	// Power fail and internal reset show on the pin, and a driven or high pin holds the core.
	a_oe_power: assert property (power_fail |-> rst_pin_oe)
		else $error("pin not driven during power fail");
	a_oe_internal: assert property (internal_reset |-> rst_pin_oe)
		else $error("pin not driven during internal reset");
	a_pin_level: assert property (rst_pin_oe |-> rst_pin_out == 1'b1)
		else $error("pin driven to the wrong level");
	a_oe_holds: assert property (rst_pin_oe |=> system_reset)
		else $error("internal reset did not hold the core");
	a_pin_holds: assert property (rst_pin_in |=> system_reset)
		else $error("core left reset while pin high");
	a_exit_bound: assert property (s_pin_release |-> s_reset_gone)
		else $error("core stayed in reset after pin release");
	a_vector_zero: assert property (reset_vector == 16'h0000)
		else $error("start address not zero");
	// Wake must follow the interrupt in idle and never appear without it.
	a_wake_idle: assert property (idle_mode && watchdog_irq |-> idle_wake)
		else $error("enabled interrupt did not wake from idle");
	a_wake_cause: assert property (idle_wake |-> watchdog_irq && idle_mode)
		else $error("wake without a watchdog interrupt");
endmodule : wdt_core_assertions

// ---- wdt_core_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin err_count++; \
	$display("wrong value at %0t: %s", $time, m); end end
module wdt_core_tb
	import wdt_pkg::*;
;
	logic        clock, nrst, reg_wr, reg_rd, rst_pin_in, power_fail, internal_reset;
	logic        stop_mode, idle_mode, rst_pin_out, rst_pin_oe, system_reset;
	logic        watchdog_irq, idle_wake, ring_clock_select, execution_hold;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
	logic [15:0] reset_vector;
	int          err_count, n_checks, n;

	wdt_core uut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rst_pin_in(rst_pin_in),
		.rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .power_fail(power_fail),
		.internal_reset(internal_reset), .stop_mode(stop_mode), .idle_mode(idle_mode),
		.crystal_enable_tick(1'b1), .system_reset(system_reset), .watchdog_irq(watchdog_irq),
		.idle_wake(idle_wake), .ring_clock_select(ring_clock_select),
		.execution_hold(execution_hold), .reset_vector(reset_vector));

	// Clock at 125 MHz.
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	// Protected bits need the key pair just before the write.
	task automatic wr_locked(input logic [7:0] v);
		wr(ADDR_TIMED_ACCESS, TA_KEY1);
		wr(ADDR_TIMED_ACCESS, TA_KEY2);
		wr(ADDR_WATCHDOG_CONTROL, v);
	endtask : wr_locked

	// Bounded wait for the core to leave reset.
	task automatic wait_run();
		n = 0;
		while (system_reset !== 1'b0 && n < 8) begin
			@(posedge clock);
			n++;
		end
		#1 `CHK(system_reset, 1'b0, "core did not leave reset")
	endtask : wait_run

	// The timeout path is about 66k clocks; allow a margin beyond it.
	initial begin
		#(8 * 100000);
		err_count++;
		give_verdict();
	end

	initial begin
		{nrst, reg_wr, reg_rd, rst_pin_in, power_fail, internal_reset} = '0;
		{stop_mode, idle_mode, reg_addr, reg_wdata} = '0;
		{err_count, n_checks} = '0;
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		wait_run();
		`CHK(execution_hold, 1'b1, "execution ran before crystal warm-up")
		rd(ADDR_CLOCK_CONTROL, d);
		`CHK(d[7:6], TIMEOUT_RESET, "timeout select reset value")
		rd(ADDR_POWER_MGMT, d);
		`CHK(d[7:6], DIVIDE_RESET, "divide field reset value")
		rd(8'h3f, d);
		`CHK(d, 8'h00, "unmapped read not zero")
		$display("test reset values done");
		// Enable without the key pair must be ignored.
		wr(ADDR_WATCHDOG_CONTROL, 8'h02);
		rd(ADDR_WATCHDOG_CONTROL, d);
		`CHK(d[BIT_RESET_EN], 1'b0, "unprotected write took effect")
		wr_locked(8'h03);
		rd(ADDR_WATCHDOG_CONTROL, d);
		`CHK(d[BIT_RESET_EN], 1'b1, "unlocked write ignored")
		$display("test timed access done");
		// Divide 00 with ratio 0 and shortest select, then restart for a full interval.
		wr(ADDR_EXT_IRQ_ENABLE, 8'h10);
		wr(ADDR_POWER_MGMT, 8'h00);
		wr(ADDR_CLOCK_CONTROL, 8'h00);
		wr_locked(8'h03);
		idle_mode <= 1'b1;
		n = 0;
		while (watchdog_irq !== 1'b1 && n < 70000) begin
			@(posedge clock) #1;
			n++;
		end
		`CHK(watchdog_irq, 1'b1, "no watchdog interrupt")
		`CHK(idle_wake, 1'b1, "enabled interrupt did not wake from idle")
		`CHK(rst_pin_oe, 1'b0, "reset came with the interrupt")
		n = 0;
		while (rst_pin_oe !== 1'b1 && n < 600) begin
			@(posedge clock) #1;
			n++;
		end
		idle_mode <= 1'b0;
		`CHK(n, 512, "reset not 512 clocks after interrupt")
		`CHK(rst_pin_oe, 1'b1, "enabled watchdog gave no reset")
		@(posedge clock);
		#1 `CHK(system_reset, 1'b1, "watchdog reset did not hold core")
		wait_run();
		rd(ADDR_WATCHDOG_CONTROL, d);
		`CHK(d[BIT_RESET_FLAG], 1'b1, "reset flag not set")
		rd(ADDR_POWER_MGMT, d);
		`CHK(d[7:6], DIVIDE_RESET, "divide not back to default")
		rd(ADDR_EXT_IRQ_ENABLE, d);
		`CHK(d[BIT_IRQ_ENABLE], 1'b0, "irq enable survived reset")
		`CHK(watchdog_irq, 1'b0, "irq forwarded while disabled")
		$display("test watchdog timeout done");
		// Pin held for three clocks, then power fail and internal reset in turn.
		@(posedge clock);
		rst_pin_in <= 1'b1;
		repeat (3) @(posedge clock);
		#1 `CHK(system_reset, 1'b1, "pin did not hold reset")
		rst_pin_in <= 1'b0;
		wait_run();
		for (int i = 0; i < 2; i++) begin
			@(posedge clock);
			power_fail <= (i == 0);
			internal_reset <= (i == 1);
			@(posedge clock);
			#1 `CHK(rst_pin_oe, 1'b1, "pin not driven by internal reset")
			`CHK(system_reset, 1'b1, "core not held by internal reset")
			{power_fail, internal_reset} <= 2'b00;
			wait_run();
		end
		`CHK(reset_vector, 16'h0000, "start address not zero")
		`CHK(execution_hold, 1'b0, "warm-up never finished")
		`CHK(ring_clock_select, 1'b0, "ring selected without stop exit")
		`CHK(rst_pin_out, 1'b1, "pin drive level not high")
		`CHK(idle_wake, 1'b0, "wake outside idle")
		$display("test reset pin done");
		give_verdict();
	end
endmodule : wdt_core_tb

bind wdt_core wdt_core_assertions chk (.clock(clock), .nrst(nrst), .rst_pin_in(rst_pin_in),
	.rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .power_fail(power_fail),
	.internal_reset(internal_reset), .idle_mode(idle_mode), .watchdog_irq(watchdog_irq),
	.idle_wake(idle_wake), .system_reset(system_reset), .reset_vector(reset_vector));
